/* File: src/trig_ack_defines.svh */
`ifndef TRIG_ACK_DEFINES_SVH
`define TRIG_ACK_DEFINES_SVH

`define OUT_TRIG_ACK_OFFSET   12'h010
`define APP_TRIG_SET_OFFSET   12'h014
`define APP_TRIG_CLEAR_OFFSET 12'h018
`define NUM_OUT_TRIG          10
`define NUM_CHANNELS          4
`define APP_TRIG_RESET        4'h0

`endif

/* File: src/trig_ack_pkg.sv */
package trig_ack_pkg;
   typedef logic [9:0] trig_vec_t;
   typedef logic [3:0] chan_vec_t;
endpackage

/* File: src/trig_ack_app.sv */
`timescale 1ns/1ps
`include "trig_ack_defines.svh"
module trig_ack_app (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic [3:0]             implemented_trigger_count,
   input  wire trig_ack_pkg::trig_vec_t channel_to_trigger_map,
   input  wire trig_ack_pkg::trig_vec_t trig_connected,
   input  wire trig_ack_pkg::trig_vec_t trig_self_ack,
   input  wire logic                   global_mapping_enable,
   input  wire logic                   software_lock_state,
   input  wire trig_ack_pkg::chan_vec_t other_channel_events,
   output trig_ack_pkg::trig_vec_t     out_trigger,
   output trig_ack_pkg::chan_vec_t     channel_event_out,
   output trig_ack_pkg::chan_vec_t     app_trigger_state
);

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic wr_en;
   logic ack_wr;
   logic set_wr;
   logic clr_wr;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   // locked writes are dropped silently
   assign wr_en  = psel && penable && pwrite && !software_lock_state;
   assign ack_wr = wr_en && (paddr == `OUT_TRIG_ACK_OFFSET);
   assign set_wr = wr_en && (paddr == `APP_TRIG_SET_OFFSET);
   assign clr_wr = wr_en && (paddr == `APP_TRIG_CLEAR_OFFSET);

   a_lock_no_write: assert property (@(posedge pclk) disable iff (!presetn)
      software_lock_state |-> !wr_en)
      else $error("write accepted while locked");

   a_decode_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot0({ack_wr, set_wr, clr_wr}))
      else $error("more than one register decoded");

   // ----------------------------------------
   // output trigger latch and acknowledge
   // ----------------------------------------
   trig_ack_pkg::trig_vec_t trig_reg;
   trig_ack_pkg::trig_vec_t trig_next;
   trig_ack_pkg::trig_vec_t ack_ok;

   always_comb begin
      for (int i = 0; i < `NUM_OUT_TRIG; i++) begin
         ack_ok[i] = ack_wr && pwdata[i]
                     && (4'(i) < implemented_trigger_count)
                     && trig_connected[i]
                     && !trig_self_ack[i]
                     && !channel_to_trigger_map[i];
      end
      // new triggers only while enabled; latched ones persist
      trig_next = trig_reg;
      if (global_mapping_enable) begin
         trig_next = trig_next | channel_to_trigger_map;
      end
      // clearing an inactive bit is a no-op by construction
      trig_next = trig_next & ~ack_ok;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_reg <= '0;
      end else begin
         trig_reg <= trig_next;
      end
   end
   assign out_trigger = trig_reg;

   a_ack_mapped: assert property (@(posedge pclk) disable iff (!presetn)
      presetn && channel_to_trigger_map[0] && global_mapping_enable |=> trig_reg[0])
      else $error("trigger dropped while mapping active");

   a_ack_map_block: assert property (@(posedge pclk) disable iff (!presetn)
      (ack_ok & channel_to_trigger_map) == 10'h000)
      else $error("ack accepted while mapping output active");

   a_ack_count: assert property (@(posedge pclk) disable iff (!presetn)
      ack_wr && pwdata[9] && trig_reg[9] && implemented_trigger_count <= 4'h9 |=> trig_reg[9])
      else $error("ack accepted above trigger count");

   a_ack_count_edge: assert property (@(posedge pclk) disable iff (!presetn)
      ack_wr && pwdata[8] && trig_reg[8] && implemented_trigger_count <= 4'h8 |=> trig_reg[8])
      else $error("ack accepted for unimplemented trigger");

   a_ack_unconnected: assert property (@(posedge pclk) disable iff (!presetn)
      (ack_ok & ~trig_connected) == 10'h000)
      else $error("ack accepted for unconnected trigger");

   a_ack_self: assert property (@(posedge pclk) disable iff (!presetn)
      (ack_ok & trig_self_ack) == 10'h000)
      else $error("ack accepted for self acknowledging trigger");

   a_ack_locked: assert property (@(posedge pclk) disable iff (!presetn)
      software_lock_state |-> ack_ok == 10'h000)
      else $error("ack accepted while locked");

   a_ack_deactivates: assert property (@(posedge pclk) disable iff (!presetn)
      ack_ok != 10'h000 |=> (trig_reg & $past(ack_ok)) == 10'h000)
      else $error("acknowledged trigger still active");

   a_ack_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      ack_wr && !pwdata[0] && trig_reg[0] |=> trig_reg[0])
      else $error("zero ack bit deactivated trigger");

   a_ack_inactive: assert property (@(posedge pclk) disable iff (!presetn)
      ack_wr && !trig_reg[5] && !(global_mapping_enable && channel_to_trigger_map[5])
      |=> !trig_reg[5])
      else $error("ack of inactive trigger changed it");

   a_ack_upper_bits: assert property (@(posedge pclk) disable iff (!presetn)
      ack_wr && pwdata[9:0] == 10'h000 |=> (~trig_reg & $past(trig_reg)) == 10'h000)
      else $error("upper ack bits deactivated a trigger");

   a_trig_persist: assert property (@(posedge pclk) disable iff (!presetn)
      trig_reg[1] && !ack_ok[1] |=> trig_reg[1])
      else $error("trigger lost without acknowledge");

   a_trig_drop_ack: assert property (@(posedge pclk) disable iff (!presetn)
      trig_reg != 10'h000 |=> (~trig_reg & $past(trig_reg))
      == ($past(trig_reg) & $past(ack_ok)))
      else $error("trigger dropped without acknowledge");

   a_no_new_trig: assert property (@(posedge pclk) disable iff (!presetn)
      !global_mapping_enable && !trig_reg[2] |=> !trig_reg[2])
      else $error("new trigger without global enable");

   a_trig_no_rise: assert property (@(posedge pclk) disable iff (!presetn)
      !global_mapping_enable |=> (trig_reg & ~$past(trig_reg)) == 10'h000)
      else $error("trigger raised with global enable off");

   a_trig_latch: assert property (@(posedge pclk) disable iff (!presetn)
      presetn && global_mapping_enable |=> (trig_reg & $past(channel_to_trigger_map))
      == $past(channel_to_trigger_map))
      else $error("mapping output not latched");

   // ----------------------------------------
   // application trigger state
   // ----------------------------------------
   trig_ack_pkg::chan_vec_t app_reg;
   trig_ack_pkg::chan_vec_t app_next;

   always_comb begin
      app_next = app_reg;
      if (clr_wr) begin
         app_next = app_next & ~pwdata[3:0];
      end
      if (set_wr) begin
         app_next = app_next | pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         app_reg <= `APP_TRIG_RESET;
      end else begin
         app_reg <= app_next;
      end
   end
   assign app_trigger_state = app_reg;

   a_app_set_effect: assert property (@(posedge pclk) disable iff (!presetn)
      set_wr && !clr_wr |=> ((app_reg & $past(pwdata[3:0])) == $past(pwdata[3:0])))
      else $error("app set write did not set state");

   a_app_clear_effect: assert property (@(posedge pclk) disable iff (!presetn)
      clr_wr && !set_wr |=> ((app_reg & $past(pwdata[3:0])) == 4'h0))
      else $error("app clear write did not clear state");

   a_app_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !set_wr && !clr_wr |=> $stable(app_reg))
      else $error("app state changed without write");

   a_lock_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      software_lock_state |=> $stable(app_reg))
      else $error("app state changed while locked");

   a_app_set_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      set_wr |=> (app_reg & ~$past(pwdata[3:0])) == ($past(app_reg) & ~$past(pwdata[3:0])))
      else $error("zero set bit changed state");

   a_app_clr_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      clr_wr |=> (app_reg & ~$past(pwdata[3:0])) == ($past(app_reg) & ~$past(pwdata[3:0])))
      else $error("zero clear bit changed state");

   a_app_upper_set: assert property (@(posedge pclk) disable iff (!presetn)
      set_wr && pwdata[3:0] == 4'h0 |=> $stable(app_reg))
      else $error("upper set bits changed state");

   a_app_reset: assert property (@(posedge pclk)
      $rose(presetn) |-> app_reg == `APP_TRIG_RESET)
      else $error("app state not zero after reset");

   // ----------------------------------------
   // channel events
   // ----------------------------------------
   trig_ack_pkg::chan_vec_t chan_reg;
   trig_ack_pkg::chan_vec_t chan_next;

   always_comb begin
      chan_next = other_channel_events;
      if (global_mapping_enable) begin
         chan_next = chan_next | app_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_reg <= '0;
      end else begin
         chan_reg <= chan_next;
      end
   end
   assign channel_event_out = chan_reg;

   a_chan_merge: assert property (@(posedge pclk) disable iff (!presetn)
      presetn && global_mapping_enable |=> channel_event_out
      == ($past(other_channel_events) | $past(app_reg)))
      else $error("channel events miss app state");

   a_chan_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      presetn && !global_mapping_enable |=> channel_event_out == $past(other_channel_events))
      else $error("app state driven with global enable off");

   a_chan_set_event: assert property (@(posedge pclk) disable iff (!presetn)
      set_wr && global_mapping_enable ##1 global_mapping_enable
      |=> (channel_event_out & $past(pwdata[3:0], 2)) == $past(pwdata[3:0], 2))
      else $error("set write raised no channel event");

   a_chan_clr_event: assert property (@(posedge pclk) disable iff (!presetn)
      clr_wr ##1 1'b1
      |=> (channel_event_out & $past(pwdata[3:0], 2) & ~$past(other_channel_events)) == 4'h0)
      else $error("clear write left channel event");

   // ----------------------------------------
   // read data
   // ----------------------------------------
   logic [31:0] rd_next;
   logic [31:0] rd_reg;

   always_comb begin
      rd_next = rd_reg;
      if (psel && !penable && !pwrite) begin
         rd_next = 32'h0000_0000;
         if (paddr == `APP_TRIG_SET_OFFSET) begin
            rd_next = {28'h000_0000, app_reg};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_reg <= 32'h0000_0000;
      end else begin
         rd_reg <= rd_next;
      end
   end
   assign prdata = rd_reg;

   a_read_set: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == `APP_TRIG_SET_OFFSET
      |=> prdata == {28'h000_0000, $past(app_reg)})
      else $error("set readback wrong");

   a_read_ack_zero: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == `OUT_TRIG_ACK_OFFSET
      |=> prdata == 32'h0000_0000)
      else $error("ack register read not zero");

   a_read_clr_zero: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == `APP_TRIG_CLEAR_OFFSET
      |=> prdata == 32'h0000_0000)
      else $error("clear register read not zero");

   a_read_stands: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data changed outside read setup");

endmodule

/* File: dv/trig_net_model.sv */
`timescale 1ns/1ps
module trig_net_model (
   input  wire logic                     pclk,
   input  wire trig_ack_pkg::trig_vec_t  map_req,
   output trig_ack_pkg::trig_vec_t       map_out,
   output trig_ack_pkg::trig_vec_t       connected,
   output trig_ack_pkg::trig_vec_t       self_ack,
   output logic [3:0]                    trig_count,
   output trig_ack_pkg::chan_vec_t       other_events
);
   // mapping outputs come out of a registered network, one edge late
   always_ff @(posedge pclk) begin
      map_out <= map_req;
   end
   assign connected    = 10'h3fd; // trigger 1 left unconnected
   assign self_ack     = 10'h004; // trigger 2 acknowledges itself
   assign trig_count   = 4'h8;
   assign other_events = 4'h1;
endmodule

/* File: dv/cti_trigger_ack_and_app_trigger_test.sv */
`timescale 1ns/1ps
module trig_ack_app_test;
   logic                    pclk, presetn, psel, penable, pwrite, en, lock, pready, pslverr;
   logic [11:0]             paddr;
   logic [31:0]             pwdata, prdata, q;
   logic [3:0]              cnt;
   trig_ack_pkg::trig_vec_t map_req, map_out, conn, sack, outt;
   trig_ack_pkg::chan_vec_t oth, chev, apst;
   int                      miscompares, tests_run;

   trig_net_model net (.pclk(pclk), .map_req(map_req), .map_out(map_out), .connected(conn),
      .self_ack(sack), .trig_count(cnt), .other_events(oth));
   trig_ack_app uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .implemented_trigger_count(cnt), .channel_to_trigger_map(map_out),
      .trig_connected(conn), .trig_self_ack(sack), .global_mapping_enable(en),
      .software_lock_state(lock), .other_channel_events(oth), .out_trigger(outt),
      .channel_event_out(chev), .app_trigger_state(apst));

   task wrap_up;
      if (miscompares == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer; leaves read data in q
   task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 50) begin
            miscompares++;
            wrap_up();
         end
         @(posedge pclk);
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task setin(input logic e, input logic l, input logic [9:0] m);
      @(posedge pclk);
      en <= e;
      lock <= l;
      map_req <= m;
   endtask

   task wt;
      repeat (2) @(posedge pclk);
      #1;
   endtask

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   initial begin
      #200000;
      miscompares++;
      wrap_up();
   end

   initial begin
      {psel, penable, pwrite, en, lock} = '0;
      presetn = 1'b0;
      paddr = '0;
      pwdata = '0;
      map_req = '0;
      miscompares = 0;
      tests_run = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      setin(1, 0, 10'h000);
      acc(0, 12'h014, 0); chk("set_reset", 32'h0, q);
      acc(1, 12'h014, 32'hffffffff);
      acc(0, 12'h014, 0); chk("set_read", 32'hf, q);
      wt; chk("chan_all", 32'hf, 32'(chev));
      acc(1, 12'h018, 32'h5);
      acc(1, 12'h014, 32'h0);
      wt; chk("state_clr", 32'ha, 32'(apst));
      chk("chan_clr", 32'hb, 32'(chev));
      acc(0, 12'h018, 0); chk("clr_read", 32'h0, q);
      acc(0, 12'h020, 0); chk("unmapped", 32'h0, q);
      setin(1, 1, 10'h000);
      acc(1, 12'h018, 32'hf);
      acc(1, 12'h014, 32'hf);
      wt; chk("locked_set", 32'ha, 32'(apst));
      setin(0, 0, 10'h000);
      wt; chk("chan_off", 32'h1, 32'(chev));
      setin(1, 0, 10'h3ff);
      wt;
      setin(0, 0, 10'h008);
      wt; chk("trig_hold", 32'h3ff, 32'(outt));
      setin(0, 1, 10'h008);
      acc(1, 12'h010, 32'h3ff);
      wt; chk("ack_locked", 32'h3ff, 32'(outt));
      chk("locked_err", 32'h0, 32'(pslverr));
      setin(0, 0, 10'h008);
      acc(1, 12'h010, 32'h0);
      wt; chk("ack_zero", 32'h3ff, 32'(outt));
      acc(1, 12'h010, 32'hffffffff);
      wt; chk("ack_mask", 32'h30e, 32'(outt));
      acc(0, 12'h010, 0); chk("ack_read", 32'h0, q);
      setin(0, 0, 10'h000);
      acc(1, 12'h010, 32'h9);
      wt; chk("ack_free", 32'h306, 32'(outt));
      setin(0, 0, 10'h001);
      wt; chk("no_new", 32'h306, 32'(outt));
      wrap_up();
   end
endmodule
